//--- logic/dsm_cfg.svh
// Register offsets, field positions and reset values of the data signal modulator.
`ifndef DSM_CFG_SVH
`define DSM_CFG_SVH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define DSM_OFS_CONTROL   8'h00
`define DSM_OFS_MOD_SRC   8'h04
`define DSM_OFS_CAR_HIGH  8'h08
`define DSM_OFS_CAR_LOW   8'h0C

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define DSM_BIT_ENABLE    7
`define DSM_BIT_OUT_INV   4
`define DSM_BIT_OUT_STATE 3
`define DSM_BIT_SW_MOD    0
`define DSM_BIT_CAR_INV   6
`define DSM_BIT_CAR_SYNC  5

// ---------------------------------------------------------------------------
// Source codes and reset values
// ---------------------------------------------------------------------------
`define DSM_CODE_SW_BIT   4'h0
`define DSM_CODE_GROUND   4'h0
`define DSM_CODE_RESERVED 4'h9
`define DSM_MOD_CCP_ONE   4'h2
`define DSM_MOD_CCP_TWO   4'h3
`define DSM_CAR_CCP_ONE   4'h4
`define DSM_CAR_CCP_TWO   4'h5
`define DSM_RST_CONTROL   8'h00
`define DSM_RST_SELECT    8'h00

`endif

//--- logic/dsm_pkg.sv
// Types shared by the data signal modulator.
package dsm_pkg;

    // Control register fields.
    typedef struct packed {
        logic enable;
        logic out_inv;
        logic sw_mod;
    } dsm_control_s;

    // One carrier control register.
    typedef struct packed {
        logic       inv;
        logic       sync;
        logic [3:0] sel;
    } dsm_carrier_cfg_s;

endpackage

//--- logic/dsm_modulator.sv
// Data signal modulator with a classic Wishbone register slave.
//
// Our own choices: the register offsets and register access over Wishbone.
`include "dsm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dsm_modulator
    import dsm_pkg::*;
#(
    parameter int SRC_W = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic             wb_we_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic [SRC_W-1:0] carrier_src_i,
    input  wire logic [SRC_W-1:0] mod_src_i,
    input  wire logic [1:0]       ccp_pwm_mode_i,
    output logic                  mod_out_o
);

    // -----------------------------------------------------------------------
    // Source selection
    // -----------------------------------------------------------------------
    // Returns the carrier for a code; ground and the reserved code give zero.
    function automatic logic carrier_pick(input logic [SRC_W-1:0] src,
                                          input logic [3:0]       code);
        logic v;
        v = src[code];
        if (code == `DSM_CODE_GROUND || code == `DSM_CODE_RESERVED) begin
            v = 1'b0;
        end
        return v;
    endfunction

    // -----------------------------------------------------------------------
    // Registers and state
    // -----------------------------------------------------------------------
    dsm_control_s     ctrl;
    logic [3:0]       mod_sel;
    dsm_carrier_cfg_s car_high;
    dsm_carrier_cfg_s car_low;

    logic [2*SRC_W-1:0] sync1;
    logic [2*SRC_W-1:0] sync2;
    logic [2*SRC_W-1:0] sync3;
    logic [2*SRC_W-1:0] filt;

    logic high_prev;
    logic low_prev;
    logic use_high;
    logic use_low;

    // -----------------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------------
    // A bit changes only once the second and third stages agree.
    wire [2*SRC_W-1:0] pin_in    = {carrier_src_i, mod_src_i};
    wire [2*SRC_W-1:0] differ    = sync2 ^ sync3;
    wire [2*SRC_W-1:0] next_filt = (sync3 & ~differ) | (filt & differ);

    always_ff @(posedge clk_i) begin
        sync1 <= pin_in;
        sync2 <= sync1;
        sync3 <= sync2;
        if (rst_i) begin
            filt <= '0;
        end else begin
            filt <= next_filt;
        end
    end

    wire [SRC_W-1:0] car_raw = filt[2*SRC_W-1:SRC_W];
    wire [SRC_W-1:0] mod_raw = filt[SRC_W-1:0];

    // Capture/compare outputs count only while those units run as PWM.
    logic [SRC_W-1:0] car_gated;
    logic [SRC_W-1:0] mod_gated;
    always_comb begin
        car_gated = car_raw;
        mod_gated = mod_raw;
        car_gated[`DSM_CAR_CCP_ONE] = car_raw[`DSM_CAR_CCP_ONE]
                                      & ccp_pwm_mode_i[0];
        car_gated[`DSM_CAR_CCP_TWO] = car_raw[`DSM_CAR_CCP_TWO]
                                      & ccp_pwm_mode_i[1];
        mod_gated[`DSM_MOD_CCP_ONE] = mod_raw[`DSM_MOD_CCP_ONE]
                                      & ccp_pwm_mode_i[0];
        mod_gated[`DSM_MOD_CCP_TWO] = mod_raw[`DSM_MOD_CCP_TWO]
                                      & ccp_pwm_mode_i[1];
    end

    // -----------------------------------------------------------------------
    // Carrier and modulator paths
    // -----------------------------------------------------------------------
    // While disabled the carrier picks are grounded ahead of the invert bits and the stored codes remain.
    wire high_pick = ctrl.enable
                   & carrier_pick(car_gated, car_high.sel);
    wire low_pick  = ctrl.enable
                   & carrier_pick(car_gated, car_low.sel);
    wire high_car  = high_pick ^ car_high.inv;
    wire low_car   = low_pick ^ car_low.inv;

    wire use_hw_mod = ctrl.enable && (mod_sel != `DSM_CODE_SW_BIT);
    wire modulator  = use_hw_mod ? mod_gated[mod_sel]
                                 : ctrl.sw_mod;

    // Falling edges are taken after inversion.
    wire high_fall = high_prev & ~high_car;
    wire low_fall  = low_prev & ~low_car;

    // A synchronised carrier changes its enable only at its own falling
    // edge, so it runs on after the switch away and waits before resuming.
    wire next_use_high = (car_high.sync && !high_fall) ? use_high
                                                      : modulator;
    wire next_use_low  = (car_low.sync && !low_fall) ? use_low
                                                    : ~modulator;

    wire mixed   = (high_car & use_high) | (low_car & use_low);
    wire next_out = ctrl.enable & (mixed ^ ctrl.out_inv);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            high_prev <= 1'b0;
            low_prev  <= 1'b0;
            use_high  <= 1'b0;
            use_low   <= 1'b0;
            mod_out_o <= 1'b0;
        end else begin
            high_prev <= high_car;
            low_prev  <= low_car;
            use_high  <= next_use_high;
            use_low   <= next_use_low;
            mod_out_o <= next_out;
        end
    end

    // -----------------------------------------------------------------------
    // Wishbone slave
    // -----------------------------------------------------------------------
    wire       req      = wb_cyc_i & wb_stb_i;
    wire       mapped   = (wb_adr_i[7:4] == 4'h0);
    wire [7:0] word_adr = {wb_adr_i[7:2], 2'b00};
    wire       wr_lane  = req & wb_we_i & wb_ack_o & wb_sel_i[0] & mapped;
    wire       wr_ctrl  = wr_lane && (word_adr == `DSM_OFS_CONTROL);
    wire       wr_msrc  = wr_lane && (word_adr == `DSM_OFS_MOD_SRC);
    wire       wr_high  = wr_lane && (word_adr == `DSM_OFS_CAR_HIGH);
    wire       wr_low   = wr_lane && (word_adr == `DSM_OFS_CAR_LOW);

    // Reserved bits read zero and the output state bit is read-only.
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        case (word_adr)
            `DSM_OFS_CONTROL: begin
                rd_byte[`DSM_BIT_ENABLE]    = ctrl.enable;
                rd_byte[`DSM_BIT_OUT_INV]   = ctrl.out_inv;
                rd_byte[`DSM_BIT_OUT_STATE] = mod_out_o;
                rd_byte[`DSM_BIT_SW_MOD]    = ctrl.sw_mod;
            end
            `DSM_OFS_MOD_SRC: begin
                rd_byte[3:0] = mod_sel;
            end
            `DSM_OFS_CAR_HIGH: begin
                rd_byte[`DSM_BIT_CAR_INV]  = car_high.inv;
                rd_byte[`DSM_BIT_CAR_SYNC] = car_high.sync;
                rd_byte[3:0]               = car_high.sel;
            end
            `DSM_OFS_CAR_LOW: begin
                rd_byte[`DSM_BIT_CAR_INV]  = car_low.inv;
                rd_byte[`DSM_BIT_CAR_SYNC] = car_low.sync;
                rd_byte[3:0]               = car_low.sel;
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    wire [31:0] next_rd = mapped ? {24'h000000, rd_byte} : 32'h00000000;

    // Each request gets one ack a cycle after it is seen; ack drops next.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            wb_dat_o <= next_rd;
        end
    end

    // -----------------------------------------------------------------------
    // Register file
    // -----------------------------------------------------------------------
    localparam logic [7:0] RST_CTRL = `DSM_RST_CONTROL;
    localparam logic [7:0] RST_SEL  = `DSM_RST_SELECT;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl.enable   <= RST_CTRL[`DSM_BIT_ENABLE];
            ctrl.out_inv  <= RST_CTRL[`DSM_BIT_OUT_INV];
            ctrl.sw_mod   <= RST_CTRL[`DSM_BIT_SW_MOD];
            mod_sel       <= RST_SEL[3:0];
            car_high      <= '{inv: RST_SEL[`DSM_BIT_CAR_INV],
                               sync: RST_SEL[`DSM_BIT_CAR_SYNC],
                               sel: RST_SEL[3:0]};
            car_low       <= '{inv: RST_SEL[`DSM_BIT_CAR_INV],
                               sync: RST_SEL[`DSM_BIT_CAR_SYNC],
                               sel: RST_SEL[3:0]};
        end else begin
            if (wr_ctrl) begin
                ctrl.enable  <= wb_dat_i[`DSM_BIT_ENABLE];
                ctrl.out_inv <= wb_dat_i[`DSM_BIT_OUT_INV];
                ctrl.sw_mod  <= wb_dat_i[`DSM_BIT_SW_MOD];
            end
            if (wr_msrc) begin
                mod_sel <= wb_dat_i[3:0];
            end
            if (wr_high) begin
                car_high.inv  <= wb_dat_i[`DSM_BIT_CAR_INV];
                car_high.sync <= wb_dat_i[`DSM_BIT_CAR_SYNC];
                car_high.sel  <= wb_dat_i[3:0];
            end
            if (wr_low) begin
                car_low.inv  <= wb_dat_i[`DSM_BIT_CAR_INV];
                car_low.sync <= wb_dat_i[`DSM_BIT_CAR_SYNC];
                car_low.sel  <= wb_dat_i[3:0];
            end
        end
    end

endmodule

`default_nettype wire

//--- testbench/dsm_modulator_properties.sv
// Concurrent checks on the modulator register bus and output.
`timescale 1ns/1ps
`default_nettype none
module dsm_modulator_properties #(
    parameter int SRC_W = 16
) (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic [7:0]       wb_adr_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic             wb_we_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    input wire logic [SRC_W-1:0] carrier_src_i,
    input wire logic [SRC_W-1:0] mod_src_i,
    input wire logic [1:0]       ccp_pwm_mode_i,
    input wire logic             mod_out_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic       en;
    logic [3:0] off_cnt;
    wire rd_ack = wb_ack_o && !wb_we_i;
    wire ctl = wb_adr_i[7:2] == 6'h00;
    wire wr_ctl = wb_ack_o && wb_we_i && wb_sel_i[0] && ctl;
    wire req = wb_cyc_i && wb_stb_i;
    // Shadow of the enable bit and a count of cycles spent disabled.
    always_ff @(posedge clk_i) begin
        en <= rst_i ? 1'b0 : (wr_ctl ? wb_dat_i[7] : en);
        off_cnt <= (rst_i || en) ? 4'h0 : off_cnt + {3'h0, off_cnt != 4'hF};
    end
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in one cycle");
    a_ack_idle: assert property (!req |=> !wb_ack_o)
        else $error("ack without a request");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_unmapped_zero: assert property (rd_ack && wb_adr_i[7:4] != 4'h0
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_ctrl_fields: assert property (rd_ack && ctl |-> wb_dat_o[7] == en
        && wb_dat_o[6:5] == 2'b00 && wb_dat_o[2:1] == 2'b00)
        else $error("control read back wrong");
    a_sel_fields: assert property (rd_ack && !ctl && wb_adr_i[7:4] == 4'h0
        |-> wb_dat_o[7] == 1'b0 && wb_dat_o[4] == 1'b0)
        else $error("select register reserved bit set");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i
        |=> !wb_ack_o && !mod_out_o) else $error("activity after reset");
    a_off_low: assert property (off_cnt == 4'hF |-> !mod_out_o)
        else $error("output high while disabled");
endmodule
bind dsm_modulator dsm_modulator_properties #(.SRC_W(SRC_W)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .carrier_src_i(carrier_src_i), .mod_src_i(mod_src_i),
    .ccp_pwm_mode_i(ccp_pwm_mode_i), .mod_out_o(mod_out_o));
`default_nettype wire

//--- testbench/dsm_source_model.sv
// Behavioural on-chip sources that feed the modulator selectors.
`timescale 1ns/1ps
`default_nettype none
module dsm_source_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] car_lvl_i,
    input  wire logic [15:0] mod_lvl_i,
    input  wire logic [1:0]  pwm_i,
    output logic      [15:0] carrier_src_o,
    output logic      [15:0] mod_src_o,
    output logic      [1:0]  ccp_pwm_mode_o
);
    // Sources change just after an edge, like peripheral outputs.
    always_ff @(posedge clk_i) begin
        carrier_src_o <= car_lvl_i;
        mod_src_o <= mod_lvl_i;
        ccp_pwm_mode_o <= pwm_i;
    end
endmodule
`default_nettype wire

//--- testbench/dsm_modulator_test.sv
// Register and output tests of the data signal modulator.
`timescale 1ns/1ps
`default_nettype none
module dsm_modulator_test;
    logic        clk_i, rst_i, we, cyc, stb;
    logic [7:0]  adr;
    logic [31:0] dat, rdat;
    logic [3:0]  sel;
    logic [15:0] car, modl;
    logic [1:0]  pwm;
    wire  [31:0] dat_o;
    wire  [15:0] cs, ms;
    wire  [1:0]  pm;
    wire         ack, out;
    int          bad_count, check_count, i;
    dsm_modulator #(.SRC_W(16)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .carrier_src_i(cs), .mod_src_i(ms), .ccp_pwm_mode_i(pm),
        .mod_out_o(out));
    dsm_source_model u_src (.clk_i(clk_i), .car_lvl_i(car), .mod_lvl_i(modl),
        .pwm_i(pwm), .carrier_src_o(cs), .mod_src_o(ms), .ccp_pwm_mode_o(pm));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [7:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_i);
        {adr, we, dat, sel, cyc, stb} <= {a, w, 24'h0, d, s, 2'b11};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n == 40) bad_count++;
        rdat = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h00, 4'hF);
        cmp(rdat, {24'h0, e});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d, 4'h1);
    endtask
    // The sources pass a synchroniser and filter before the output settles.
    task automatic chk_out(input logic e);
        repeat (12) @(posedge clk_i);
        cmp({31'h0, out}, {31'h0, e});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        stop_test();
    end
    initial begin
        {we, cyc, stb, adr, dat, sel, car, modl, pwm} = '0;
        rst_i = 1'b1;
        bad_count = 0;
        check_count = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 16; i += 4) rd(i[7:0], 8'h00);
        for (i = 4; i < 16; i += 4) wr(i[7:0], 8'hFF);
        rd(8'h04, 8'h0F);
        rd(8'h08, 8'h6F);
        rd(8'h0C, 8'h6F);
        wr(8'h00, 8'h6E);
        rd(8'h00, 8'h00);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        xfer(8'h04, 1'b1, 8'h00, 4'h0);
        rd(8'h04, 8'h0F);
        $display("register test done");
        wr(8'h04, 8'h00);
        wr(8'h0C, 8'h00);
        for (i = 0; i < 32; i++) begin
            car[1] <= i[0];
            wr(8'h08, {1'b0, i[1], 6'h01});
            wr(8'h00, {i[4], 2'b00, i[3], 3'b000, i[2]});
            chk_out(i[4] & ((i[2] & (i[0] ^ i[1])) ^ i[3]));
        end
        $display("output function test done");
        wr(8'h08, 8'h40);
        pwm <= 2'b11;
        wr(8'h00, 8'h80);
        for (i = 1; i < 16; i++) begin
            wr(8'h04, i[7:0]);
            modl <= 16'h0001 << i;
            chk_out(1'b1);
            modl <= 16'h0000;
            chk_out(1'b0);
        end
        pwm <= 2'b00;
        modl <= 16'h000C;
        wr(8'h04, 8'h02);
        chk_out(1'b0);
        wr(8'h04, 8'h03);
        chk_out(1'b0);
        $display("modulation source test done");
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h81);
        pwm <= 2'b11;
        for (i = 0; i < 16; i++) begin
            car <= 16'h0001 << i;
            wr(8'h08, i[7:0]);
            chk_out(i != 0 && i != 9);
        end
        pwm <= 2'b00;
        car <= 16'h0030;
        wr(8'h08, 8'h04);
        chk_out(1'b0);
        wr(8'h08, 8'h40);
        chk_out(1'b1);
        rd(8'h00, 8'h89);
        $display("carrier source test done");
        // High carrier sync: it runs on until its own falling edge.
        car <= 16'h0002;
        wr(8'h08, 8'h01);
        chk_out(1'b1);
        wr(8'h08, 8'h21);
        wr(8'h00, 8'h80);
        chk_out(1'b1);
        car <= 16'h0000;
        chk_out(1'b0);
        car <= 16'h0002;
        chk_out(1'b0);
        wr(8'h00, 8'h81);
        chk_out(1'b0);
        car <= 16'h0000;
        chk_out(1'b0);
        car <= 16'h0002;
        chk_out(1'b1);
        $display("high carrier sync test done");
        // Low carrier select, invert and sync.
        wr(8'h08, 8'h00);
        wr(8'h0C, 8'h42);
        wr(8'h00, 8'h80);
        chk_out(1'b1);
        car <= 16'h0004;
        chk_out(1'b0);
        wr(8'h0C, 8'h22);
        chk_out(1'b1);
        wr(8'h00, 8'h81);
        chk_out(1'b1);
        car <= 16'h0000;
        chk_out(1'b0);
        $display("low carrier sync test done");
        stop_test();
    end
endmodule
`default_nettype wire
